// ==== sim/cpvfm_adc_model.sv ====
// Purpose: Measurement engine model answering adc_start with one result set
// Assumes: Results come from the bench, latency from the lat input
// Notes: Result lines read all ones until the first done pulse, then carry inverted data outside it
module cpvfm_adc_model #(
  parameter int NUM_CELLS = 8
) (
  // Clock
  input wire logic aclk,
  // Engine link
  input wire logic adc_start,
  output logic adc_done,
  output logic [NUM_CELLS*8-1:0] adc_cells,
  output logic [7:0] adc_pack,
  // Bench control
  input wire logic [NUM_CELLS*8-1:0] cells_in,
  input wire logic [7:0] pack_in,
  input wire logic [3:0] lat
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    adc_done = 1'b0;
    adc_cells = '1;
    adc_pack = 8'hFF;
  end
  // Stale data is inverted so a late sample cannot pass by chance
  always begin
    @(negedge aclk);
    if (adc_start === 1'b1) begin
      repeat (lat) @(posedge aclk);
      adc_cells <= cells_in;
      adc_pack <= pack_in;
      adc_done <= 1'b1;
      @(posedge aclk);
      adc_done <= 1'b0;
      adc_cells <= ~cells_in;
      adc_pack <= ~pack_in;
    end
  end
endmodule

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench of the voltage fault monitor
// Assumes: AXI4-Lite master tasks, reads checked from a queue of notes
// Notes: Results random within 0x40..0xBF so thresholds never wrap
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, alert, dse, cse;
  logic awready, wready, bvalid, arready, rvalid, adc_start, adc_done;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, lat;
  logic [1:0] bresp, rresp;
  logic [63:0] cells, adc_cells;
  logic [7:0] pack, adc_pack, mn, mx;
  logic [9:0] q[$];
  int bad_count, num_checks, seed;
  cpvfm_monitor dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .adc_start(adc_start), .adc_done(adc_done), .adc_cells(adc_cells), .adc_pack(adc_pack),
    .alert(alert), .discharge_switch_enable(dse), .charge_switch_enable(cse));
  cpvfm_adc_model part_u (.aclk(aclk), .adc_start(adc_start), .adc_done(adc_done),
    .adc_cells(adc_cells), .adc_pack(adc_pack), .cells_in(cells), .pack_in(pack), .lat(lat));
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // The bus tasks wr, rd and scan start and end just after a rising edge
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic a, w, b;
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      if (b) chk("bresp", 10'h0, {8'h0, bresp});
      // Bready stays high between writes; each valid drops after the edge that took it, so no beat is sent twice
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] i, input logic [1:0] r, input logic [7:0] d);
    logic a, v;
    q.push_back({r, d});
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge aclk);
      a = arvalid && arready;
      v = rvalid;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
    end
  endtask
  task automatic scan();
    lat <= 4'h1 + 4'($random(seed) & 7);
    wr(cpvfm_pkg::IDX_SCAN_CTRL, 8'h02);
    wr(cpvfm_pkg::IDX_SCAN_CTRL, 8'h03);
    @(negedge adc_done);
    repeat (2) @(posedge aclk);
  endtask
  // Read data is judged against the oldest note at the handshake
  always @(negedge aclk) begin
    if (rvalid && rready) chk("rdata", q.pop_front(), {rresp, rdata[7:0]});
  end
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    #3000000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    lat = 4'h1;
    seed = 21333;
    mn = 8'hFF;
    mx = 8'h00;
    pack = 8'h40 + 8'($random(seed) & 8'h7F);
    for (int k = 0; k < 8; k++) begin
      cells[8*k+:8] = 8'h40 + 8'($random(seed) & 8'h7F);
      if (cells[8*k+:8] < mn) mn = cells[8*k+:8];
      if (cells[8*k+:8] > mx) mx = cells[8*k+:8];
    end
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(cpvfm_pkg::IDX_CELL_MASK, 2'h0, 8'hFF);
    rd(cpvfm_pkg::IDX_SWITCH_CTRL, 2'h0, 8'h00);
    rd(8'h10, 2'h2, 8'h00);
    $display("reset and map test done");
    wr(cpvfm_pkg::IDX_CELL_UV_THR, mx + 8'h1);
    wr(cpvfm_pkg::IDX_PACK_UV_THR, pack + 8'h1);
    scan();
    rd(cpvfm_pkg::IDX_CELL_RES, 2'h0, cells[7:0]);
    rd(cpvfm_pkg::IDX_PACK_RES, 2'h0, pack);
    rd(cpvfm_pkg::IDX_CELL_STAT, 2'h0, 8'h02);
    rd(cpvfm_pkg::IDX_PACK_STAT, 2'h0, 8'h40);
    chk("alert", 10'h0, {9'h0, alert});
    wr(cpvfm_pkg::IDX_CELL_MASK, 8'hFD);
    repeat (2) @(posedge aclk);
    chk("alert", 10'h1, {9'h0, alert});
    $display("forced low test done");
    wr(cpvfm_pkg::IDX_CELL_UV_THR, mn);
    wr(cpvfm_pkg::IDX_PACK_UV_THR, pack);
    scan();
    rd(cpvfm_pkg::IDX_CELL_STAT, 2'h0, 8'h02);
    wr(cpvfm_pkg::IDX_FAULT_CLEAR, 8'h02);
    repeat (2) @(posedge aclk);
    chk("alert", 10'h0, {9'h0, alert});
    rd(cpvfm_pkg::IDX_CELL_STAT, 2'h0, 8'h00);
    scan();
    rd(cpvfm_pkg::IDX_PACK_STAT, 2'h0, 8'h00);
    $display("latch and clear test done");
    wr(cpvfm_pkg::IDX_SWITCH_CTRL, 8'h13);
    repeat (2) @(posedge aclk);
    chk("switches", 10'h3, {8'h0, dse, cse});
    wr(cpvfm_pkg::IDX_CELL_UV_THR, mn + 8'h1);
    wr(cpvfm_pkg::IDX_CELL_OV_THR, mn - 8'h1);
    wr(cpvfm_pkg::IDX_PACK_OV_THR, pack - 8'h1);
    wr(cpvfm_pkg::IDX_PACK_MASK, 8'h7F);
    scan();
    rd(cpvfm_pkg::IDX_CELL_STAT, 2'h0, 8'h03);
    rd(cpvfm_pkg::IDX_PACK_STAT, 2'h0, 8'h80);
    chk("switches", 10'h0, {8'h0, dse, cse});
    chk("alert", 10'h1, {9'h0, alert});
    wr(cpvfm_pkg::IDX_SWITCH_CTRL, 8'h00);
    rd(cpvfm_pkg::IDX_SWITCH_CTRL, 2'h0, 8'h00);
    $display("high and isolation test done");
    report_and_stop();
  end
endmodule

// ==== src/cpvfm_fault_filter.sv ====
// Purpose: Consecutive-violation filter for one fault condition
// Assumes: Sample pulses once per finished scan
// Notes: Commanded scans bypass the count
module cpvfm_fault_filter #(
  parameter int FILTER_COUNT = 3
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sample
  input wire logic sample,
  input wire logic bypass,
  input wire logic violation,
  // Result
  output logic detect
);

  localparam int CNT_W = $clog2(FILTER_COUNT + 1);

  if (FILTER_COUNT < 1) begin : g_chk
    $error("FILTER_COUNT must be at least one");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } cpvfm_filt_state_t;

  cpvfm_filt_state_t st_ff;
  cpvfm_filt_state_t nxt_st;
  logic at_limit;

  assign at_limit = st_ff.cnt == CNT_W'(FILTER_COUNT - 1);
  assign detect = sample && violation && (bypass || at_limit); // [RULE_22]

  always_comb begin
    nxt_st = st_ff;
    if (sample) begin
      // Saturate so a lasting violation keeps reporting every scan
      if (bypass || !violation) begin
        nxt_st.cnt = '0;
      end else if (!at_limit) begin
        nxt_st.cnt = st_ff.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// ==== src/cpvfm_monitor.sv ====
// Purpose: Cell and pack voltage fault monitor with AXI4-Lite registers
// Assumes: Measurement engine on aclk; 10 MHz clock
// Notes: Byte address is four times the register index
// Functional notes
// [RULE_01] After a scan every cell and the pack are compared, flags set after filter
// [RULE_02] Any cell or pack below its low threshold raises a low-voltage fault
// [RULE_03] Pack low threshold has its own register, apart from the cell one
// [RULE_04] Host runs a full scan before judging any fault flag
// [RULE_05] Cell low fault in status bit 0x63.1, pack low in 0x65.6
// [RULE_06] Low faults reach the alert pin only with their gate bit cleared
// [RULE_07] High faults reach the alert pin only with their gate bit cleared
// [RULE_08] Host polls the status or reacts to the alert pin
// [RULE_09] Host sets its own fault flag on a low flag and reacts
// [RULE_10] Host reacts by clearing discharge or charge switch enables
// [RULE_11] Self-test: host sets low thresholds above the highest reading
// [RULE_12] Host reads cell and pack results to pick the thresholds
// [RULE_13] Forced-fault scan must set the flag, else host alerts
// [RULE_14] Clear-all bit clears latched faults; host sets no-fault thresholds
// [RULE_15] No-fault scan must leave the flag clear, else host alerts
// [RULE_16] With auto bits set, faults switch the power switches off
// [RULE_17] On a fault the device isolates the pack itself and alerts; here only with the group's auto bit set, alert only when unmasked
// [RULE_18] Host fetches measurements and checks them against its own limits
// [RULE_19] Host redundant check isolates the pack and alerts on fault
// [RULE_20] Host compares cell sum with pack reading
// [RULE_21] Host sets scan select, clears then sets trigger to start scan
// [RULE_22] Consecutive filtering only in continuous mode, bypassed on full scan
// [RULE_23] Cell high fault in bit 0x63.0, pack high in 0x65.7
// [RULE_24] Fault flags stay latched until the clear-all bit is written
// [RULE_25] Alert drops once no unmasked flag remains
//
// The AXI4-Lite register port was left to the implementer.
module cpvfm_monitor #(
  parameter int NUM_CELLS = 8,
  parameter int FILTER_COUNT = 3
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [cpvfm_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [cpvfm_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [cpvfm_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [cpvfm_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Measurement engine
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [NUM_CELLS*8-1:0] adc_cells,
  input wire logic [7:0] adc_pack,
  // Protection outputs
  output logic alert,
  output logic discharge_switch_enable,
  output logic charge_switch_enable
);

  // ************************************************************
  // Checks and state
  // ************************************************************
  if (NUM_CELLS < 1 || NUM_CELLS > cpvfm_pkg::CELL_SLOTS) begin : g_chk
    $error("NUM_CELLS out of range");
  end

  typedef struct packed {
    logic aw_have;
    logic [cpvfm_pkg::ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [7:0] w_byte;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rbyte;
    logic [1:0] rresp;
    logic [7:0] scan_ctrl;
    logic [7:0] cell_ov_thr;
    logic [7:0] cell_uv_thr;
    logic [7:0] pack_ov_thr;
    logic [7:0] pack_uv_thr;
    logic [7:0] switch_ctrl;
    logic [7:0] cell_mask;
    logic [7:0] pack_mask;
    logic [NUM_CELLS-1:0][7:0] cell_res;
    logic [7:0] pack_res;
    logic [cpvfm_pkg::NUM_COND-1:0] flags;
    logic busy;
    logic full_scan;
    logic adc_start;
    logic alert;
  } cpvfm_state_t;

  cpvfm_state_t st_ff;
  cpvfm_state_t nxt_st;

  logic [7:0] ar_idx;
  logic [7:0] wr_idx;
  logic do_write;
  logic wr_lane;
  logic clear_all;
  logic full_req;
  logic sample;
  logic [cpvfm_pkg::NUM_COND-1:0] viol;
  logic [cpvfm_pkg::NUM_COND-1:0] det;
  logic [cpvfm_pkg::NUM_COND-1:0] gate_now;

  // ************************************************************
  // Register decode helpers
  // ************************************************************
  function automatic logic cell_hit(input logic [7:0] idx);
    logic [7:0] off;
    off = idx - cpvfm_pkg::IDX_CELL_RES;
    cell_hit = (idx >= cpvfm_pkg::IDX_CELL_RES) && (off < 8'(NUM_CELLS));
  endfunction

  function automatic logic is_mapped(input logic [7:0] idx);
    case (idx)
      cpvfm_pkg::IDX_SCAN_CTRL, cpvfm_pkg::IDX_FAULT_CLEAR,
      cpvfm_pkg::IDX_CELL_OV_THR, cpvfm_pkg::IDX_CELL_UV_THR,
      cpvfm_pkg::IDX_PACK_OV_THR, cpvfm_pkg::IDX_PACK_UV_THR,
      cpvfm_pkg::IDX_SWITCH_CTRL, cpvfm_pkg::IDX_PACK_RES,
      cpvfm_pkg::IDX_CELL_STAT, cpvfm_pkg::IDX_PACK_STAT,
      cpvfm_pkg::IDX_CELL_MASK, cpvfm_pkg::IDX_PACK_MASK: is_mapped = 1'b1;
      default: is_mapped = cell_hit(idx);
    endcase
  endfunction

  function automatic logic [7:0] read_byte(input logic [7:0] idx, input cpvfm_state_t s);
    logic [7:0] off;
    logic [7:0] v;
    off = idx - cpvfm_pkg::IDX_CELL_RES;
    v = 8'h00;
    case (idx)
      cpvfm_pkg::IDX_SCAN_CTRL: begin
        v = s.scan_ctrl;
        v[cpvfm_pkg::BUSY_BIT] = s.busy;
      end
      cpvfm_pkg::IDX_CELL_OV_THR: v = s.cell_ov_thr;
      cpvfm_pkg::IDX_CELL_UV_THR: v = s.cell_uv_thr;
      cpvfm_pkg::IDX_PACK_OV_THR: v = s.pack_ov_thr;
      cpvfm_pkg::IDX_PACK_UV_THR: v = s.pack_uv_thr;
      cpvfm_pkg::IDX_SWITCH_CTRL: v = s.switch_ctrl;
      cpvfm_pkg::IDX_PACK_RES: v = s.pack_res;
      cpvfm_pkg::IDX_CELL_STAT: begin
        v[cpvfm_pkg::CELL_HIGH_BIT] = s.flags[cpvfm_pkg::COND_CELL_HIGH]; // [RULE_23]
        v[cpvfm_pkg::CELL_LOW_BIT] = s.flags[cpvfm_pkg::COND_CELL_LOW]; // [RULE_05]
      end
      cpvfm_pkg::IDX_PACK_STAT: begin
        v[cpvfm_pkg::PACK_LOW_BIT] = s.flags[cpvfm_pkg::COND_PACK_LOW]; // [RULE_05]
        v[cpvfm_pkg::PACK_HIGH_BIT] = s.flags[cpvfm_pkg::COND_PACK_HIGH]; // [RULE_23]
      end
      cpvfm_pkg::IDX_CELL_MASK: v = s.cell_mask;
      cpvfm_pkg::IDX_PACK_MASK: v = s.pack_mask;
      default: begin
        if (cell_hit(idx)) begin
          v = s.cell_res[off[cpvfm_pkg::CELL_IW-1:0]]; // [RULE_18]
        end
      end
    endcase
    read_byte = v;
  endfunction

  function automatic logic [cpvfm_pkg::NUM_COND-1:0] gates(input logic [7:0] cm,
                                                          input logic [7:0] pm);
    logic [cpvfm_pkg::NUM_COND-1:0] g;
    g = '0;
    g[cpvfm_pkg::COND_CELL_HIGH] = cm[cpvfm_pkg::CELL_HIGH_BIT];
    g[cpvfm_pkg::COND_CELL_LOW] = cm[cpvfm_pkg::CELL_LOW_BIT];
    g[cpvfm_pkg::COND_PACK_LOW] = pm[cpvfm_pkg::PACK_LOW_BIT];
    g[cpvfm_pkg::COND_PACK_HIGH] = pm[cpvfm_pkg::PACK_HIGH_BIT];
    gates = g;
  endfunction

  // ************************************************************
  // Compare and filter
  // ************************************************************
  cpvfm_threshold_cmp #(.NUM_CELLS(NUM_CELLS)) u_cmp (
    .cells(adc_cells),
    .pack(adc_pack),
    .cell_uv_thr(st_ff.cell_uv_thr),
    .cell_ov_thr(st_ff.cell_ov_thr),
    .pack_uv_thr(st_ff.pack_uv_thr),
    .pack_ov_thr(st_ff.pack_ov_thr),
    .cell_low(viol[cpvfm_pkg::COND_CELL_LOW]),
    .cell_high(viol[cpvfm_pkg::COND_CELL_HIGH]),
    .pack_low(viol[cpvfm_pkg::COND_PACK_LOW]),
    .pack_high(viol[cpvfm_pkg::COND_PACK_HIGH])
  );

  assign sample = st_ff.busy && adc_done;

  for (genvar c = 0; c < cpvfm_pkg::NUM_COND; c++) begin : g_filt
    cpvfm_fault_filter #(.FILTER_COUNT(FILTER_COUNT)) u_filt (
      .aclk(aclk),
      .aresetn(aresetn),
      .sample(sample),
      .bypass(st_ff.full_scan), // [RULE_22]
      .violation(viol[c]),
      .detect(det[c])
    );
  end

  // ************************************************************
  // Bus handshake and next state
  // ************************************************************
  assign awready = !st_ff.aw_have && !st_ff.bvalid;
  assign wready = !st_ff.w_have && !st_ff.bvalid;
  assign arready = !st_ff.rvalid;
  assign ar_idx = araddr[cpvfm_pkg::ADDR_W-1:2];
  assign wr_idx = st_ff.aw_addr[cpvfm_pkg::ADDR_W-1:2];
  assign do_write = st_ff.aw_have && st_ff.w_have;
  assign wr_lane = do_write && st_ff.w_lane;
  assign clear_all = wr_lane && (wr_idx == cpvfm_pkg::IDX_FAULT_CLEAR)
                     && st_ff.w_byte[cpvfm_pkg::CLEAR_ALL_BIT];
  assign full_req = wr_lane && (wr_idx == cpvfm_pkg::IDX_SCAN_CTRL)
                    && !st_ff.scan_ctrl[cpvfm_pkg::TRIG_BIT]
                    && st_ff.w_byte[cpvfm_pkg::TRIG_BIT]
                    && st_ff.w_byte[cpvfm_pkg::SCAN_SEL_BIT];
  assign gate_now = gates(st_ff.cell_mask, st_ff.pack_mask);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.adc_start = 1'b0;
    if (awvalid && awready) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_st.w_have = 1'b1;
      nxt_st.w_byte = wdata[7:0];
      nxt_st.w_lane = wstrb[0];
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rbyte = read_byte(ar_idx, st_ff);
      nxt_st.rresp = is_mapped(ar_idx) ? cpvfm_pkg::RESP_OKAY : cpvfm_pkg::RESP_SLVERR;
    end
    if (do_write) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = is_mapped(wr_idx) ? cpvfm_pkg::RESP_OKAY : cpvfm_pkg::RESP_SLVERR;
      if (st_ff.w_lane) begin
        case (wr_idx)
          cpvfm_pkg::IDX_SCAN_CTRL: nxt_st.scan_ctrl = st_ff.w_byte;
          cpvfm_pkg::IDX_CELL_OV_THR: nxt_st.cell_ov_thr = st_ff.w_byte;
          cpvfm_pkg::IDX_CELL_UV_THR: nxt_st.cell_uv_thr = st_ff.w_byte;
          cpvfm_pkg::IDX_PACK_OV_THR: nxt_st.pack_ov_thr = st_ff.w_byte;
          cpvfm_pkg::IDX_PACK_UV_THR: nxt_st.pack_uv_thr = st_ff.w_byte; // [RULE_03]
          cpvfm_pkg::IDX_SWITCH_CTRL: nxt_st.switch_ctrl = st_ff.w_byte;
          cpvfm_pkg::IDX_CELL_MASK: nxt_st.cell_mask = st_ff.w_byte;
          cpvfm_pkg::IDX_PACK_MASK: nxt_st.pack_mask = st_ff.w_byte;
          default: nxt_st.scan_ctrl = nxt_st.scan_ctrl;
        endcase
      end
    end
    // Scan launch; a commanded scan that lands while busy is dropped
    if (!st_ff.busy && (full_req || (st_ff.scan_ctrl[cpvfm_pkg::TRIG_BIT]
        && !st_ff.scan_ctrl[cpvfm_pkg::SCAN_SEL_BIT]))) begin
      nxt_st.busy = 1'b1;
      nxt_st.full_scan = full_req;
      nxt_st.adc_start = 1'b1;
    end
    if (sample) begin
      nxt_st.busy = 1'b0;
      nxt_st.cell_res = adc_cells;
      nxt_st.pack_res = adc_pack;
    end
    // A detection in the clearing cycle survives the clear
    nxt_st.flags = (st_ff.flags & ~{cpvfm_pkg::NUM_COND{clear_all}}) | det; // [RULE_24] [RULE_14]
    // Hardware isolation overrides a software write in the same cycle
    if (((det[cpvfm_pkg::COND_CELL_LOW] || det[cpvfm_pkg::COND_CELL_HIGH])
         && nxt_st.switch_ctrl[cpvfm_pkg::CELL_AUTO_BIT])
        || ((det[cpvfm_pkg::COND_PACK_LOW] || det[cpvfm_pkg::COND_PACK_HIGH])
         && nxt_st.switch_ctrl[cpvfm_pkg::PACK_AUTO_BIT])) begin
      nxt_st.switch_ctrl[cpvfm_pkg::DISCHARGE_SW_BIT] = 1'b0; // [RULE_16] [RULE_17]
      nxt_st.switch_ctrl[cpvfm_pkg::CHARGE_SW_BIT] = 1'b0; // [RULE_16]
    end
    nxt_st.alert = |(nxt_st.flags & ~gates(nxt_st.cell_mask, nxt_st.pack_mask)); // [RULE_06] [RULE_07] [RULE_25]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.scan_ctrl <= cpvfm_pkg::RST_SCAN;
      st_ff.cell_ov_thr <= cpvfm_pkg::RST_OV_THR;
      st_ff.pack_ov_thr <= cpvfm_pkg::RST_OV_THR;
      st_ff.cell_uv_thr <= cpvfm_pkg::RST_UV_THR;
      st_ff.pack_uv_thr <= cpvfm_pkg::RST_UV_THR;
      st_ff.switch_ctrl <= cpvfm_pkg::RST_SWITCH;
      st_ff.cell_mask <= cpvfm_pkg::RST_MASK;
      st_ff.pack_mask <= cpvfm_pkg::RST_MASK;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign rvalid = st_ff.rvalid;
  assign rresp = st_ff.rresp;
  assign rdata = {24'h000000, st_ff.rbyte};
  assign adc_start = st_ff.adc_start;
  assign alert = st_ff.alert;
  assign discharge_switch_enable = st_ff.switch_ctrl[cpvfm_pkg::DISCHARGE_SW_BIT];
  assign charge_switch_enable = st_ff.switch_ctrl[cpvfm_pkg::CHARGE_SW_BIT];

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_full_done;
    sample && st_ff.full_scan;
  endsequence

  sequence s_launch;
    full_req && !st_ff.busy;
  endsequence

  property p_full_scan_start;
    s_launch |=> adc_start && st_ff.busy && st_ff.full_scan ##1 !adc_start;
  endproperty
  a_full_scan_start: assert property (p_full_scan_start) else $error("full scan not launched"); // [RULE_01]

  property p_cell_low_set;
    s_full_done ##0 viol[cpvfm_pkg::COND_CELL_LOW] |=> st_ff.flags[cpvfm_pkg::COND_CELL_LOW];
  endproperty
  a_cell_low_set: assert property (p_cell_low_set) else $error("cell low flag missed"); // [RULE_02]

  property p_pack_low_set;
    s_full_done ##0 viol[cpvfm_pkg::COND_PACK_LOW] |=> st_ff.flags[cpvfm_pkg::COND_PACK_LOW];
  endproperty
  a_pack_low_set: assert property (p_pack_low_set) else $error("pack low flag missed"); // [RULE_03]

  property p_high_set;
    s_full_done ##0 (viol[cpvfm_pkg::COND_CELL_HIGH] || viol[cpvfm_pkg::COND_PACK_HIGH])
      |=> (st_ff.flags[cpvfm_pkg::COND_CELL_HIGH] || st_ff.flags[cpvfm_pkg::COND_PACK_HIGH]);
  endproperty
  a_high_set: assert property (p_high_set) else $error("high flag missed"); // [RULE_23]

  property p_latched;
    (st_ff.flags != '0) && !clear_all |=> ($past(st_ff.flags) & ~st_ff.flags) == '0;
  endproperty
  a_latched: assert property (p_latched) else $error("flag dropped without clear"); // [RULE_24]

  property p_clear_all;
    clear_all && !sample |=> st_ff.flags == '0 ##1 !alert;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear all failed"); // [RULE_14]

  property p_gated_quiet;
    (st_ff.flags & ~gate_now) == '0 |-> !alert;
  endproperty
  a_gated_quiet: assert property (p_gated_quiet) else $error("alert without unmasked flag"); // [RULE_06]

  property p_high_alert;
    st_ff.flags[cpvfm_pkg::COND_CELL_HIGH] && !gate_now[cpvfm_pkg::COND_CELL_HIGH] |-> alert;
  endproperty
  a_high_alert: assert property (p_high_alert) else $error("cell high alert missing"); // [RULE_07]

  property p_alert_drop;
    alert ##1 ((st_ff.flags & ~gate_now) == '0) |-> !alert;
  endproperty
  a_alert_drop: assert property (p_alert_drop) else $error("alert stuck"); // [RULE_25]

  property p_auto_iso;
    sample && det[cpvfm_pkg::COND_CELL_LOW] && st_ff.switch_ctrl[cpvfm_pkg::CELL_AUTO_BIT]
      |=> !discharge_switch_enable && !charge_switch_enable && (alert || st_ff.cell_mask[1]);
  endproperty
  a_auto_iso: assert property (p_auto_iso) else $error("auto isolation failed"); // [RULE_16]

endmodule

// ==== src/cpvfm_pkg.sv ====
// Purpose: Shared constants of the cell and pack voltage fault monitor
// Assumes: 8-bit registers, each on one aligned 32-bit word at 4 x index
// Notes: Register indices are kept as printed; byte address is index times four
package cpvfm_pkg;

  // ************************************************************
  // Bus
  // ************************************************************
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Register indices
  // ************************************************************
  localparam logic [7:0] IDX_SCAN_CTRL = 8'h01;
  localparam logic [7:0] IDX_FAULT_CLEAR = 8'h02;
  localparam logic [7:0] IDX_CELL_OV_THR = 8'h06;
  localparam logic [7:0] IDX_CELL_UV_THR = 8'h07;
  localparam logic [7:0] IDX_PACK_OV_THR = 8'h20;
  localparam logic [7:0] IDX_PACK_UV_THR = 8'h21;
  localparam logic [7:0] IDX_SWITCH_CTRL = 8'h24;
  localparam logic [7:0] IDX_CELL_RES = 8'h31;
  localparam logic [7:0] IDX_CELL_RES_LAST = 8'h4F;
  localparam logic [7:0] IDX_PACK_RES = 8'h5C;
  localparam logic [7:0] IDX_CELL_STAT = 8'h63;
  localparam logic [7:0] IDX_PACK_STAT = 8'h65;
  localparam logic [7:0] IDX_CELL_MASK = 8'h83;
  localparam logic [7:0] IDX_PACK_MASK = 8'h85;
  localparam int CELL_SLOTS = 31;
  localparam int CELL_IW = 5;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int TRIG_BIT = 0;
  localparam int SCAN_SEL_BIT = 1;
  localparam int BUSY_BIT = 7;
  localparam int CLEAR_ALL_BIT = 1;
  localparam int CHARGE_SW_BIT = 0;
  localparam int DISCHARGE_SW_BIT = 1;
  localparam int PACK_AUTO_BIT = 3;
  localparam int CELL_AUTO_BIT = 4;
  localparam int CELL_HIGH_BIT = 0;
  localparam int CELL_LOW_BIT = 1;
  localparam int PACK_LOW_BIT = 6;
  localparam int PACK_HIGH_BIT = 7;

  // Condition order inside the flag vector
  localparam int COND_CELL_HIGH = 0;
  localparam int COND_CELL_LOW = 1;
  localparam int COND_PACK_LOW = 2;
  localparam int COND_PACK_HIGH = 3;
  localparam int NUM_COND = 4;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] RST_SWITCH = 8'h00;
  localparam logic [7:0] RST_UV_THR = 8'h00;
  localparam logic [7:0] RST_OV_THR = 8'hFF;
  localparam logic [7:0] RST_SCAN = 8'h00;

endpackage

// ==== src/cpvfm_threshold_cmp.sv ====
// Purpose: Compare one result set against the cell and pack thresholds
// Assumes: Unsigned 8-bit codes; purely combinational
// Notes: Low means strictly below, high means strictly above
module cpvfm_threshold_cmp #(
  parameter int NUM_CELLS = 8
) (
  // Results
  input wire logic [NUM_CELLS-1:0][7:0] cells,
  input wire logic [7:0] pack,
  // Thresholds
  input wire logic [7:0] cell_uv_thr,
  input wire logic [7:0] cell_ov_thr,
  input wire logic [7:0] pack_uv_thr,
  input wire logic [7:0] pack_ov_thr,
  // Violations
  output logic cell_low,
  output logic cell_high,
  output logic pack_low,
  output logic pack_high
);

  logic [NUM_CELLS-1:0] below;
  logic [NUM_CELLS-1:0] above;

  // ************************************************************
  // Per-cell compare
  // ************************************************************
  for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
    assign below[i] = cells[i] < cell_uv_thr; // [RULE_01]
    assign above[i] = cells[i] > cell_ov_thr;
  end

  assign cell_low = |below; // [RULE_02]
  assign cell_high = |above;
  assign pack_low = pack < pack_uv_thr; // [RULE_03]
  assign pack_high = pack > pack_ov_thr;

endmodule
